// ---- hw/ulsep_pkg.sv ----
// Purpose: shared constants and types of the low-speed endpoint manager
// Assumes: one clock, 200 MHz; 8-bit register port, 9-bit addresses
// Notes:   all state of the top module is one packed struct declared here
package ulsep_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
  localparam int IDLE_W = 24;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [8:0] REG_SCRATCH = 9'h180;
  localparam logic [8:0] REG_CTRL = 9'h190;
  localparam logic [8:0] REG_XARG = 9'h191;
  localparam logic [8:0] REG_XCMD = 9'h192;
  localparam logic [8:0] REG_INT_STAT = 9'h193;
  localparam logic [8:0] REG_INT_CLR = 9'h194;
  localparam logic [8:0] REG_INT_EN = 9'h195;
  localparam logic [8:0] REG_DEV_ADDR = 9'h196;
  localparam logic [8:0] REG_ENUM = 9'h197;
  localparam logic [8:0] REG_XSTAT = 9'h198;
  localparam int CTRL_INIT = 0;
  localparam int CTRL_EP2IN = 1;
  localparam int XCMD_DIR_IN = 2;
  localparam int XS_SETUP = 3;

  // ----------------------------------------------------------------
  // enumeration states, as seen in the status register
  // ----------------------------------------------------------------
  localparam logic [1:0] EN_POWERED = 2'h0;
  localparam logic [1:0] EN_DEFAULT = 2'h1;
  localparam logic [1:0] EN_ADDRESSED = 2'h2;
  localparam logic [1:0] EN_CONFIGURED = 2'h3;

  // ----------------------------------------------------------------
  // buffer memory layout
  // ----------------------------------------------------------------
  localparam int RAM_BYTES = 64;
  localparam int BDT_BYTES = 24;
  localparam int BD_COUNT = BDT_BYTES / 4;
  localparam int SCR_BYTES = 16;
  localparam logic [5:0] BUF_BASE = 6'h18;
  localparam logic [3:0] MAX_PKT = 4'h8;
  localparam int BD_OWN = 7;
  localparam int BD_TOG = 6;
  localparam logic [1:0] BD_STAT_OFS = 2'h0;
  localparam logic [1:0] BD_CNT_OFS = 2'h1;
  localparam logic [1:0] BD_ADR_OFS = 2'h2;
  localparam logic [1:0] BD_RSV_OFS = 2'h3;

  // ----------------------------------------------------------------
  // tokens, requests, events
  // ----------------------------------------------------------------
  localparam logic [1:0] PID_OUT = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_SETUP = 2'h2;
  localparam logic [7:0] REQ_SET_ADDR = 8'h05;
  localparam logic [7:0] REQ_SET_CFG = 8'h09;
  localparam int RT_CLASS_BIT = 6;
  localparam int IRQ_TOKEN = 0;
  localparam int IRQ_RESET = 1;
  localparam int IRQ_IDLE = 2;
  localparam int IRQ_ACTIVITY = 3;
  localparam int IRQ_CLASS = 4;
  localparam int IRQ_W = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ENG_IDLE, ENG_RX, ENG_DROP, ENG_TX} ulsep_eng_e;
  typedef enum logic [1:0] {CPY_IDLE, CPY_TX, CPY_RX} ulsep_cpy_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } ulsep_reg_s;

  typedef struct packed {
    logic valid;
    logic [1:0] pid;
    logic [6:0] addr;
    logic [1:0] ep;
  } ulsep_tok_s;

  typedef struct packed {
    logic valid;
    logic done;
    logic [7:0] data;
  } ulsep_rx_s;

  typedef struct packed {
    logic valid;
    logic last;
    logic data1;
    logic [7:0] data;
  } ulsep_tx_s;

  typedef struct packed {
    logic [RAM_BYTES-1:0][7:0] ram;
    logic [SCR_BYTES-1:0][7:0] scr;
    logic link_on;
    logic [1:0] enum_st;
    logic [6:0] dev_addr;
    logic ep2_in_mode;
    logic suspended;
    logic [IDLE_W-1:0] idle_cnt;
    ulsep_eng_e eng;
    logic [2:0] eng_bd;
    logic [3:0] eng_ptr;
    logic eng_setup;
    ulsep_cpy_e cpy;
    logic [2:0] cpy_bd;
    logic [3:0] cpy_ptr;
    logic [3:0] cpy_cnt;
    logic [3:0] cpy_loc;
    logic [7:0] xarg;
    logic xfer_fail;
    logic [3:0] rx_count;
    logic [3:0] xstat;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic [7:0] rdata;
    ulsep_tx_s tx;
    logic hs_ack;
    logic hs_nak;
  } ulsep_state_s;

endpackage

// ---- hw/ulsep_top.sv ----
// Purpose: low-speed device endpoint buffer and enumeration manager
// Assumes: serial line logic outside delivers tokens and data bytes
// Notes:   one packed state struct, one comb fill, one register stage
//
// Behaviour
// - writing the init bit enables the link and enters powered state
// - in powered state only bus reset is acted on; traffic ignored
// - bus reset rebuilds descriptor table, enters default, address zero
// - set address request enters addressed state, answers new address
// - enumeration state readable in low two bits of status register
// - 64-byte buffer memory: 24 descriptor bytes, 40 buffer bytes
// - endpoint zero has own in and out buffers; setup never refused
// - endpoint one has two buffers; endpoint two shares one buffer
// - only endpoints one and two exist beside endpoint zero
// - transmit request gives source location, byte count, in endpoint
// - free in buffer: copy block, flip toggle, give to serial engine
// - transmit on unfetched in buffer copies nothing, flags failure
// - receive copies pending out data to destination, else failure
// - setup request with type bit 6 set goes to class handler
// - set configuration with nonzero value in addressed state enters configured state
// - setup data lands in endpoint zero out, status and event raised
// - 3 ms without activity suspends; activity then wakes the link
`timescale 1ns/100ps
`default_nettype none

module ulsep_top
  import ulsep_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES
) (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire ulsep_reg_s reg_req,
  output logic [7:0] rd_data,
  // serial line side
  input wire logic bus_reset,
  input wire logic bus_activity,
  input wire ulsep_tok_s tok,
  input wire ulsep_rx_s rx,
  output ulsep_tx_s tx,
  output logic hs_ack,
  output logic hs_nak,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] bd_at(input logic [2:0] bd,
                                       input logic [1:0] ofs);
    return {1'b0, bd, ofs};
  endfunction

  // endpoint two in and out both map onto the last buffer
  function automatic logic [5:0] buf_of(input logic [2:0] bd);
    return BUF_BASE + {(bd[2] ? 3'h4 : bd), 3'h0};
  endfunction

  function automatic logic own(input ulsep_state_s st,
                               input logic [2:0] bd);
    return st.ram[bd_at(bd, BD_STAT_OFS)][BD_OWN];
  endfunction

  // the shared buffer serves only the direction picked in control
  function automatic logic dir_ok(input logic ep2_in,
                                  input logic [2:0] bd);
    return !bd[2] || (bd[0] == ep2_in);
  endfunction

  function automatic logic [7:0] rd_mux(input ulsep_state_s st,
                                        input logic [8:0] ad);
    logic [7:0] r;
    r = 8'h00;
    if (ad[8:4] == REG_SCRATCH[8:4]) begin
      r = st.scr[ad[3:0]];
    end else if (ad == REG_CTRL) begin
      r = {6'h00, st.ep2_in_mode, st.link_on};
    end else if (ad == REG_XARG) begin
      r = st.xarg;
    end else if (ad == REG_XCMD) begin
      r = {st.rx_count, 2'b00, st.xfer_fail, st.cpy != CPY_IDLE};
    end else if (ad == REG_INT_STAT) begin
      r = {3'h0, st.irq_st};
    end else if (ad == REG_INT_EN) begin
      r = {3'h0, st.irq_en};
    end else if (ad == REG_DEV_ADDR) begin
      r = {1'b0, st.dev_addr};
    end else if (ad == REG_ENUM) begin
      r = {6'h00, st.enum_st};
    end else if (ad == REG_XSTAT) begin
      r = {4'h0, st.xstat};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ulsep_state_s s;
  ulsep_state_s n;
  logic tok_ok;
  logic [2:0] tok_bd;
  logic tok_avail;

  // ep3 and tokens for other addresses are never answered
  assign tok_ok = tok.valid && s.link_on && s.enum_st != EN_POWERED &&
                  !s.suspended && s.eng == ENG_IDLE &&
                  tok.addr == s.dev_addr && tok.ep != 2'h3;
  assign tok_bd = {tok.ep, tok.pid == PID_IN};
  assign tok_avail = own(s, tok_bd) && dir_ok(s.ep2_in_mode, tok_bd);

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic [2:0] bd;
    logic [5:0] ba;
    logic [7:0] st8;
    logic [3:0] cnt4;
    n = s;
    ev = '0;
    clr = '0;
    bd = 3'h0;
    ba = 6'h00;
    st8 = 8'h00;
    cnt4 = 4'h0;
    n.tx = '0;
    n.hs_ack = 1'b0;
    n.hs_nak = 1'b0;

    // --------------------------------------------------------------
    // register port
    // --------------------------------------------------------------
    if (reg_req.rd) begin
      n.rdata = rd_mux(s, reg_req.addr);
    end
    if (reg_req.wr) begin
      if (reg_req.addr[8:4] == REG_SCRATCH[8:4]) begin
        // scratch is locked while a copy runs
        if (s.cpy == CPY_IDLE) begin
          n.scr[reg_req.addr[3:0]] = reg_req.wdata;
        end
      end else if (reg_req.addr == REG_CTRL) begin
        if (reg_req.wdata[CTRL_INIT] && !s.link_on) begin
          n.link_on = 1'b1;
          n.enum_st = EN_POWERED;
        end
        n.ep2_in_mode = reg_req.wdata[CTRL_EP2IN];
      end else if (reg_req.addr == REG_XARG) begin
        n.xarg = reg_req.wdata;
      end else if (reg_req.addr == REG_XCMD && s.cpy == CPY_IDLE) begin
        bd = {reg_req.wdata[1:0], reg_req.wdata[XCMD_DIR_IN]};
        if (reg_req.wdata[1:0] == 2'h3 || !dir_ok(s.ep2_in_mode, bd)) begin
          n.xfer_fail = 1'b1;
        end else if (own(s, bd)) begin
          // in: not yet fetched; out: nothing received
          n.xfer_fail = 1'b1;
        end else begin
          n.xfer_fail = 1'b0;
          n.cpy = bd[0] ? CPY_TX : CPY_RX;
          n.cpy_bd = bd;
          n.cpy_ptr = 4'h0;
          n.cpy_loc = s.xarg[7:4];
          if (bd[0]) begin
            n.cpy_cnt = (s.xarg[3:0] > MAX_PKT) ? MAX_PKT : s.xarg[3:0];
          end else begin
            n.cpy_cnt = s.ram[bd_at(bd, BD_CNT_OFS)][3:0];
          end
        end
      end else if (reg_req.addr == REG_INT_CLR) begin
        clr = reg_req.wdata[IRQ_W-1:0];
      end else if (reg_req.addr == REG_INT_EN) begin
        n.irq_en = reg_req.wdata[IRQ_W-1:0];
      end
    end

    // --------------------------------------------------------------
    // copy engine, one byte a cycle
    // --------------------------------------------------------------
    ba = buf_of(s.cpy_bd) + {2'b00, s.cpy_ptr};
    st8 = s.ram[bd_at(s.cpy_bd, BD_STAT_OFS)];
    case (s.cpy)
      CPY_TX: begin
        if (s.cpy_ptr == s.cpy_cnt) begin
          st8[BD_TOG] = ~st8[BD_TOG];
          st8[BD_OWN] = 1'b1;
          n.ram[bd_at(s.cpy_bd, BD_STAT_OFS)] = st8;
          n.ram[bd_at(s.cpy_bd, BD_CNT_OFS)] = {4'h0, s.cpy_cnt};
          n.cpy = CPY_IDLE;
        end else begin
          n.ram[ba] = s.scr[s.cpy_loc + s.cpy_ptr];
          n.cpy_ptr = s.cpy_ptr + 4'h1;
        end
      end
      CPY_RX: begin
        if (s.cpy_ptr == s.cpy_cnt) begin
          st8[BD_OWN] = 1'b1;
          n.ram[bd_at(s.cpy_bd, BD_STAT_OFS)] = st8;
          n.rx_count = s.cpy_cnt;
          n.cpy = CPY_IDLE;
        end else begin
          n.scr[s.cpy_loc + s.cpy_ptr] = s.ram[ba];
          n.cpy_ptr = s.cpy_ptr + 4'h1;
        end
      end
      default: begin
      end
    endcase

    // --------------------------------------------------------------
    // serial engine side
    // --------------------------------------------------------------
    ba = buf_of(s.eng_bd) + {2'b00, s.eng_ptr};
    st8 = s.ram[bd_at(s.eng_bd, BD_STAT_OFS)];
    cnt4 = s.ram[bd_at(s.eng_bd, BD_CNT_OFS)][3:0];
    case (s.eng)
      ENG_IDLE: begin
        if (tok_ok && !bus_reset) begin
          n.eng_bd = tok_bd;
          n.eng_ptr = 4'h0;
          n.eng_setup = tok.pid == PID_SETUP;
          if (tok.pid == PID_SETUP) begin
            // setup overwrites ep0 out regardless of owner
            if (tok.ep == 2'h0) begin
              n.eng = ENG_RX;
            end
          end else if (!tok_avail) begin
            if (tok.pid == PID_IN) begin
              n.hs_nak = 1'b1;
            end else begin
              n.eng = ENG_DROP;
            end
          end else begin
            n.eng = (tok.pid == PID_IN) ? ENG_TX : ENG_RX;
          end
        end
      end
      ENG_RX: begin
        if (rx.valid && s.eng_ptr < MAX_PKT) begin
          n.ram[ba] = rx.data;
          n.eng_ptr = s.eng_ptr + 4'h1;
        end
        if (rx.done) begin
          st8[BD_OWN] = 1'b0;
          st8[BD_TOG] = ~st8[BD_TOG];
          n.ram[bd_at(s.eng_bd, BD_STAT_OFS)] = st8;
          n.ram[bd_at(s.eng_bd, BD_CNT_OFS)] = {4'h0, s.eng_ptr};
          n.xstat = {s.eng_setup, 1'b0, s.eng_bd[2:1]};
          ev[IRQ_TOKEN] = 1'b1;
          n.hs_ack = 1'b1;
          n.eng = ENG_IDLE;
          if (s.eng_setup) begin
            if (s.ram[BUF_BASE][RT_CLASS_BIT]) begin
              ev[IRQ_CLASS] = 1'b1;
            end else if (s.ram[BUF_BASE + 6'h01] == REQ_SET_ADDR) begin
              n.dev_addr = s.ram[BUF_BASE + 6'h02][6:0];
              n.enum_st = EN_ADDRESSED;
            end else if (s.ram[BUF_BASE + 6'h01] == REQ_SET_CFG &&
                         s.enum_st == EN_ADDRESSED &&
                         s.ram[BUF_BASE + 6'h02] != 8'h00) begin
              n.enum_st = EN_CONFIGURED;
            end
          end
        end
      end
      ENG_DROP: begin
        if (rx.done) begin
          n.hs_nak = 1'b1;
          n.eng = ENG_IDLE;
        end
      end
      ENG_TX: begin
        n.tx.valid = s.eng_ptr != cnt4;
        n.tx.data = s.ram[ba];
        n.tx.data1 = st8[BD_TOG];
        n.eng_ptr = s.eng_ptr + 4'h1;
        if (s.eng_ptr + 4'h1 >= cnt4) begin
          n.tx.last = 1'b1;
          st8[BD_OWN] = 1'b0;
          n.ram[bd_at(s.eng_bd, BD_STAT_OFS)] = st8;
          n.xstat = {2'b01, s.eng_bd[2:1]};
          ev[IRQ_TOKEN] = 1'b1;
          n.eng = ENG_IDLE;
        end
      end
      default: begin
        n.eng = ENG_IDLE;
      end
    endcase

    // --------------------------------------------------------------
    // idle detection and wake
    // --------------------------------------------------------------
    if (s.link_on && s.enum_st != EN_POWERED) begin
      if (s.suspended) begin
        // activity only counts as an event while suspended
        if (bus_activity) begin
          n.suspended = 1'b0;
          ev[IRQ_ACTIVITY] = 1'b1;
        end
      end else if (bus_activity || tok.valid || rx.valid) begin
        n.idle_cnt = '0;
      end else if (s.idle_cnt == IDLE_W'(IDLE_LIMIT - 1)) begin
        n.suspended = 1'b1;
        n.idle_cnt = '0;
        ev[IRQ_IDLE] = 1'b1;
      end else begin
        n.idle_cnt = s.idle_cnt + 1'b1;
      end
    end

    // --------------------------------------------------------------
    // bus reset, last so its table, state and engine writes override those above
    // --------------------------------------------------------------
    if (bus_reset && s.link_on) begin
      for (int i = 0; i < BD_COUNT; i++) begin
        bd = 3'(i);
        st8 = 8'h00;
        st8[BD_OWN] = ~bd[0];
        n.ram[bd_at(bd, BD_STAT_OFS)] = st8;
        n.ram[bd_at(bd, BD_CNT_OFS)] = 8'h00;
        n.ram[bd_at(bd, BD_ADR_OFS)] = {2'b00, buf_of(bd)};
        n.ram[bd_at(bd, BD_RSV_OFS)] = 8'h00;
      end
      n.enum_st = EN_DEFAULT;
      n.dev_addr = 7'h00;
      n.eng = ENG_IDLE;
      n.cpy = CPY_IDLE;
      n.suspended = 1'b0;
      n.idle_cnt = '0;
      ev[IRQ_RESET] = 1'b1;
    end

    // a new event beats a clear in the same cycle
    n.irq_st = (s.irq_st & ~clr) | ev;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end

  assign rd_data = s.rdata;
  assign tx = s.tx;
  assign hs_ack = s.hs_ack;
  assign hs_nak = s.hs_nak;
  assign irq = |(s.irq_st & s.irq_en);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_init_powered;
    @(posedge core_clk) disable iff (reset)
    ce && reg_req.wr && reg_req.addr == REG_CTRL &&
    reg_req.wdata[CTRL_INIT] && !s.link_on
    |=> s.link_on && s.enum_st == EN_POWERED;
  endproperty
  a_init_powered: assert property (p_init_powered)
    else $error("init did not enter powered state");

  property p_powered_quiet;
    @(posedge core_clk) disable iff (reset)
    ce && s.enum_st == EN_POWERED && !bus_reset
    |=> s.eng == ENG_IDLE && !hs_nak && !tx.valid;
  endproperty
  a_powered_quiet: assert property (p_powered_quiet)
    else $error("traffic answered before bus reset");

  property p_reset_default;
    @(posedge core_clk) disable iff (reset)
    ce && s.link_on && bus_reset
    |=> s.enum_st == EN_DEFAULT && s.dev_addr == 7'h00 &&
        own(s, 3'h0) && !own(s, 3'h1);
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("bus reset did not rebuild table");

  property p_enum_read;
    @(posedge core_clk) disable iff (reset)
    ce && reg_req.rd && reg_req.addr == REG_ENUM
    |=> rd_data == {6'h00, $past(s.enum_st)};
  endproperty
  a_enum_read: assert property (p_enum_read)
    else $error("enumeration status read wrong");

  property p_tx_busy_fail;
    @(posedge core_clk) disable iff (reset)
    ce && reg_req.wr && reg_req.addr == REG_XCMD && s.cpy == CPY_IDLE &&
    reg_req.wdata[XCMD_DIR_IN] && own(s, {reg_req.wdata[1:0], 1'b1})
    |=> s.xfer_fail && s.cpy == CPY_IDLE;
  endproperty
  a_tx_busy_fail: assert property (p_tx_busy_fail)
    else $error("transmit into busy buffer not refused");

  property p_tx_handover;
    @(posedge core_clk) disable iff (reset)
    ce && !bus_reset && s.cpy == CPY_TX && s.cpy_ptr == s.cpy_cnt
    |=> own(s, $past(s.cpy_bd)) && s.cpy == CPY_IDLE;
  endproperty
  a_tx_handover: assert property (p_tx_handover)
    else $error("copied in buffer not handed over");

  property p_in_nak;
    @(posedge core_clk) disable iff (reset)
    ce && tok_ok && !bus_reset && tok.pid == PID_IN && !tok_avail
    |=> hs_nak && !tx.valid ##1 !hs_nak;
  endproperty
  a_in_nak: assert property (p_in_nak)
    else $error("in token on empty buffer not nakked");

  property p_setup_done;
    @(posedge core_clk) disable iff (reset)
    ce && !bus_reset && s.eng == ENG_RX && s.eng_setup && rx.done
    |=> hs_ack && s.irq_st[IRQ_TOKEN] && s.xstat[XS_SETUP] &&
        !own(s, 3'h0) && s.eng == ENG_IDLE;
  endproperty
  a_setup_done: assert property (p_setup_done)
    else $error("setup completion not recorded");

endmodule

`default_nettype wire

// ---- test/ulsep_host_model.sv ----
// Purpose: host side model driving tokens and data bytes
// Assumes: shares the block clock; drives after each rising edge
// Notes:   idle token fields show inverted data so stale values never match
`timescale 1ns/100ps
`default_nettype none

module ulsep_host_model
  import ulsep_pkg::*;
(
  // clock
  input wire logic core_clk,
  // towards the block
  output var logic bus_reset,
  output var logic bus_activity,
  output var ulsep_tok_s tok,
  output var ulsep_rx_s rx,
  // from the block
  input wire ulsep_tx_s tx,
  input wire logic hs_ack,
  input wire logic hs_nak
);
  logic [7:0] rbuf [8];
  logic rd1;

  initial begin
    bus_reset = 1'b0;
    bus_activity = 1'b1;
    tok = '0;
    rx = '0;
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  task automatic pulse_reset();
    @(posedge core_clk);
    bus_reset <= 1'b1;
    @(posedge core_clk);
    bus_reset <= 1'b0;
  endtask

  // line silent for n cycles, then traffic resumes
  task automatic quiet(input int n);
    @(posedge core_clk);
    bus_activity <= 1'b0;
    repeat (n) @(posedge core_clk);
    bus_activity <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // packets
  // ----------------------------------------------------------------
  task automatic token(input logic [1:0] p, input logic [6:0] a,
                       input logic [1:0] e);
    @(posedge core_clk);
    tok <= '{1'b1, p, a, e};
    @(posedge core_clk);
    tok <= '{1'b0, ~p, ~a, ~e};
  endtask

  task automatic send(input logic [7:0] b [8], input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx <= '{1'b1, 1'b0, b[i]};
    end
    @(posedge core_clk);
    rx <= '{1'b0, 1'b1, ~b[n-1]};
    @(posedge core_clk);
    rx <= '{1'b0, 1'b0, b[n-1]};
  endtask

  // c: 0 silence, 1 ack, 2 nak, 3 data ended
  task automatic reply(output int n, output logic [1:0] c);
    n = 0;
    c = 2'h0;
    #1;
    for (int i = 0; i < 12 && c == 2'h0; i++) begin
      if (tx.valid) begin
        rbuf[n%8] = tx.data;
        rd1 = tx.data1;
        n++;
      end
      if (tx.last) c = 2'h3;
      else if (hs_ack) c = 2'h1;
      else if (hs_nak) c = 2'h2;
      else @(posedge core_clk) #1;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: self-checking bench for the endpoint manager
// Assumes: host model drives the serial side, bench the register port
// Notes:   idle limit shortened so suspend comes quickly
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import ulsep_pkg::*;
;
  localparam int IDLE = 50;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  ulsep_reg_s reg_req = '0;
  logic [7:0] rd_data;
  logic bus_reset, bus_activity, hs_ack, hs_nak, irq;
  ulsep_tok_s tok;
  ulsep_rx_s rx;
  ulsep_tx_s tx;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  logic [1:0] c;

  always #2.5 core_clk = ~core_clk;

  // freeze input held high except in one short freeze test
  ulsep_top #(.IDLE_LIMIT(IDLE)) i_dut (.core_clk(core_clk), .reset(reset),
    .ce(ce), .reg_req(reg_req), .rd_data(rd_data),
    .bus_reset(bus_reset), .bus_activity(bus_activity), .tok(tok),
    .rx(rx), .tx(tx), .hs_ack(hs_ack), .hs_nak(hs_nak), .irq(irq));

  ulsep_host_model i_host (.core_clk(core_clk), .bus_reset(bus_reset),
    .bus_activity(bus_activity), .tok(tok), .rx(rx), .tx(tx),
    .hs_ack(hs_ack), .hs_nak(hs_nak));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b0, a, d};
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk(input logic [8:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b0, a, 8'h00};
    #1 cmp(rd_data & m, e);
  endtask

  // bounded poll of the busy bit after a command
  task automatic cmd(input logic [7:0] v);
    wr(REG_XCMD, v);
    for (int i = 0; i < 20 && rd_data[0] !== 1'b0 || i == 0; i++) begin
      chk(REG_XCMD, 8'h00, 8'h00);
    end
    // a copy still busy after the poll limit counts as a mismatch
    cmp({7'h0, rd_data[0]}, 8'h00);
  endtask

  task automatic setup(input logic [6:0] a, input logic [7:0] t,
                       input logic [7:0] r, input logic [7:0] v,
                       input logic [7:0] e);
    i_host.token(PID_SETUP, a, 2'h0);
    i_host.send('{t, r, v, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 8);
    i_host.reply(n, c);
    cmp({6'h0, c}, e);
  endtask

  task automatic out2(input logic [7:0] x);
    i_host.token(PID_OUT, 7'h12, 2'h1);
    i_host.send('{x, ~x, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
    i_host.reply(n, c);
    cmp({6'h0, c}, 8'h01);
  endtask

  task automatic in1(input logic [7:0] e);
    i_host.token(PID_IN, 7'h12, 2'h1);
    i_host.reply(n, c);
    cmp({6'h0, c}, e);
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    i_host.pulse_reset();
    wr(REG_CTRL, 8'h01);
    chk(REG_ENUM, 8'h03, EN_POWERED);
    chk(REG_INT_STAT, 8'h02, 8'h00);
    i_host.token(PID_IN, 7'h00, 2'h0);
    i_host.reply(n, c);
    cmp({6'h0, c}, 8'h00);
    i_host.pulse_reset();
    chk(REG_ENUM, 8'h03, EN_DEFAULT);
    chk(REG_INT_STAT, 8'h02, 8'h02);
    cmp(i_dut.s.ram[6'h02], 8'h18);
    cmp(i_dut.s.ram[6'h16], 8'h38);
    $display("test powered and default done");
    wr(REG_INT_EN, 8'h01);
    setup(7'h00, 8'h00, REQ_SET_ADDR, 8'h12, 8'h01);
    chk(REG_XSTAT, 8'h0f, 8'h08);
    cmp({7'h0, irq}, 8'h01);
    chk(REG_ENUM, 8'h03, EN_ADDRESSED);
    chk(REG_DEV_ADDR, 8'h7f, 8'h12);
    wr(REG_INT_CLR, 8'h1f);
    chk(REG_INT_STAT, 8'h01, 8'h00);
    cmp({7'h0, irq}, 8'h00);
    setup(7'h00, 8'h00, REQ_SET_CFG, 8'h01, 8'h00);
    setup(7'h12, 8'h00, REQ_SET_CFG, 8'h01, 8'h01);
    chk(REG_ENUM, 8'h03, EN_CONFIGURED);
    wr(REG_INT_EN, 8'h00);
    setup(7'h12, 8'h40, REQ_SET_ADDR, 8'h33, 8'h01);
    chk(REG_INT_STAT, 8'h11, 8'h11);
    cmp({7'h0, irq}, 8'h00);
    chk(REG_DEV_ADDR, 8'h7f, 8'h12);
    $display("test enumeration done");
    for (int i = 0; i < 3; i++) begin
      wr(REG_SCRATCH + 9'(i), 8'ha1 + 8'(i));
    end
    wr(REG_XARG, 8'h03);
    cmd(8'h05);
    chk(REG_XCMD, 8'h02, 8'h00);
    cmd(8'h05);
    chk(REG_XCMD, 8'h02, 8'h02);
    in1(8'h03);
    cmp(8'(n), 8'h03);
    cmp({7'h0, i_host.rd1}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      cmp(i_host.rbuf[i], 8'ha1 + 8'(i));
    end
    in1(8'h02);
    $display("test transmit done");
    cmd(8'h01);
    chk(REG_XCMD, 8'h02, 8'h02);
    out2(8'h5a);
    wr(REG_XARG, 8'h40);
    cmd(8'h01);
    chk(REG_XCMD, 8'hf2, 8'h20);
    chk(REG_SCRATCH + 9'h4, 8'hff, 8'h5a);
    chk(REG_SCRATCH + 9'h5, 8'hff, 8'ha5);
    out2(8'h3c);
    cmd(8'h06);
    chk(REG_XCMD, 8'h02, 8'h02);
    cmd(8'h07);
    chk(REG_XCMD, 8'h02, 8'h02);
    chk(9'h1ff, 8'hff, 8'h00);
    // write while frozen must be dropped
    @(posedge core_clk);
    ce <= 1'b0;
    wr(REG_SCRATCH + 9'h7, 8'h77);
    ce <= 1'b1;
    chk(REG_SCRATCH + 9'h7, 8'hff, 8'h00);
    $display("test receive and limits done");
    i_host.quiet(IDLE + 10);
    chk(REG_INT_STAT, 8'h0c, 8'h0c);
    $display("test idle done");
    summarize();
  end
endmodule
`default_nettype wire
